/* lsd_consts.svh */
// Overview of operation
// - Enabled driver follows its routed control source
// - Stop entry disables drivers, clears data bits
// - Stop exit re-enables; data source stays off
// - Data bits 1:0 switch drivers, rest zero
// - Data read: stored bit, or source when enabled
// - Open-load check only enabled and undriven
// - Config: enables 1:0, open-load 3:2, rest zero
// - Status bits 1:0 show open-load result, read-only
// - Over-current sets that driver's flag bit
// - Set flag forces driver off until cleared
// - Flag write one clears, zero keeps; rest zero
// - Enable bit 7 gates interrupt from flags
// - Interrupt only in run; stop keeps flags
// - Test registers writable only in special mode
// - Trim loaded into test register after reset
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_DRIVE_LEVEL     4'h0
`define IDX_DRIVER_CONFIG   4'h1
`define IDX_TRIM_TEST_A     4'h2
`define IDX_TRIM_TEST_B     4'h3
`define IDX_SPARE_ZERO      4'h4
`define IDX_OPENLOAD_STATUS 4'h5
`define IDX_IRQ_ENABLE      4'h6
`define IDX_OC_FLAGS        4'h7
`define IDX_EVENT_STATUS    4'h8
`define IDX_EVENT_MASK      4'h9
`define REG_COUNT           10

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define CFG_BIAS_LSB        0
`define CFG_OL_LSB          2
`define IE_OC_BIT           7
`define RST_BYTE            8'h00
`define RST_PAIR            2'h0

`endif

/* lsd_pkg.sv */
package lsd_pkg;

  typedef logic [7:0] reg8_t;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_e;

endpackage

/* driver_channel.sv */
module driver_channel (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic bias_en,
  input  wire logic ol_en,
  input  wire logic data_bit,
  input  wire logic source_is_data,
  input  wire logic routed_level,
  input  wire logic oc_flag,
  input  wire logic stop_mode,
  input  wire logic ol_sense,
  output logic      src_level,
  output logic      drive_on,
  output logic      bias_on,
  output logic      ol_active,
  output logic      ol_result
);

  logic powered;
  logic next_drive_on;
  logic next_bias_on;
  logic next_ol_active;
  logic next_ol_result;

  always_comb begin
    src_level      = source_is_data ? data_bit : routed_level;
    powered        = bias_en & ~stop_mode;
    next_bias_on   = powered;
    next_drive_on  = powered & ~oc_flag & src_level;
    next_ol_active = powered & ol_en & ~src_level;
    // Result holds its last value while the check is idle
    next_ol_result = ol_active ? ol_sense : ol_result;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_on  <= 1'b0;
      bias_on   <= 1'b0;
      ol_active <= 1'b0;
      ol_result <= 1'b0;
    end else begin
      drive_on  <= next_drive_on;
      bias_on   <= next_bias_on;
      ol_active <= next_ol_active;
      ol_result <= next_ol_result;
    end
  end

endmodule

/* axi_lite_regs_port.sv */
module axi_lite_regs_port #(
  parameter int IDX_W     = 4,
  parameter int REG_COUNT = 10
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [IDX_W+1:0]   awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [IDX_W+1:0]   araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  output logic                    wr_fire,
  output logic [IDX_W-1:0]        wr_idx,
  output logic [7:0]              wr_data,
  output logic                    rd_fire,
  output logic [IDX_W-1:0]        rd_idx,
  input  wire lsd_pkg::reg8_t     rd_data
);

  logic             wr_pend;
  logic             wr_mapped;
  logic             rd_mapped;
  logic [7:0]       wd;
  logic             wbe;
  logic             next_awready;
  logic             next_wready;
  logic             next_bvalid;
  logic [1:0]       next_bresp;
  logic [IDX_W-1:0] next_wr_idx;
  logic [7:0]       next_wd;
  logic             next_wbe;
  logic             next_arready;
  logic             next_rvalid;
  logic [31:0]      next_rdata;
  logic [1:0]       next_rresp;

  // Address and data are latched separately, so either may come first
  always_comb begin
    wr_pend      = ~awready & ~wready & ~bvalid;
    wr_mapped    = 32'(wr_idx) < REG_COUNT;
    wr_fire      = wr_pend & wr_mapped & wbe;
    wr_data      = wd;
    rd_idx       = araddr[IDX_W+1:2];
    rd_mapped    = 32'(rd_idx) < REG_COUNT;
    rd_fire      = arvalid & arready & rd_mapped;
    next_awready = awready;
    next_wready  = wready;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_wr_idx  = wr_idx;
    next_wd      = wd;
    next_wbe     = wbe;
    next_arready = arready;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && awready) begin
      next_awready = 1'b0;
      next_wr_idx  = awaddr[IDX_W+1:2];
    end
    if (wvalid && wready) begin
      next_wready = 1'b0;
      next_wd     = wdata[7:0];
      next_wbe    = wstrb[0];
    end
    if (wr_pend) begin
      next_bvalid = 1'b1;
      next_bresp  = wr_mapped ? lsd_pkg::RESP_OKAY : lsd_pkg::RESP_SLVERR;
    end
    if (bvalid && bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = {24'h000000, rd_mapped ? rd_data : 8'h00};
      next_rresp   = rd_mapped ? lsd_pkg::RESP_OKAY : lsd_pkg::RESP_SLVERR;
    end
    if (rvalid && rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      wr_idx  <= '0;
      wd      <= 8'h00;
      wbe     <= 1'b0;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= 2'h0;
    end else begin
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      wr_idx  <= next_wr_idx;
      wd      <= next_wd;
      wbe     <= next_wbe;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

endmodule

/* dual_lowside_driver_ctrl.sv */
`include "lsd_consts.svh"

module dual_lowside_driver_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  input  wire logic [5:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [5:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // ------------------------------------------------------------
  // System and driver stage
  // ------------------------------------------------------------
  input  wire logic        stop_mode,
  input  wire logic        special_mode,
  input  wire logic [7:0]  trim_value,
  input  wire logic [1:0]  source_is_data,
  input  wire logic [1:0]  routed_level,
  input  wire logic [1:0]  overcurrent_detect,
  input  wire logic [1:0]  openload_sense,
  output logic             relay_out_zero,
  output logic             relay_out_one,
  output logic [1:0]       driver_bias_state,
  output logic [1:0]       openload_sensing,
  output logic             irq
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic                 wr_fire;
  logic [3:0]           wr_idx;
  logic [7:0]           wr_data;
  logic                 rd_fire;
  logic [3:0]           rd_idx;
  lsd_pkg::reg8_t       rd_data;

  logic [1:0]           drive_level_bit;
  logic [1:0]           driver_bias_on;
  logic [1:0]           openload_detect_on;
  logic                 overcurrent_irq_on;
  logic [1:0]           overcurrent_flag;
  logic [1:0]           event_status;
  logic [1:0]           event_mask;
  lsd_pkg::reg8_t       trim_test_a;
  lsd_pkg::reg8_t       trim_test_b;
  logic                 trim_loaded;
  logic                 stop_seen;
  logic                 irq_q;

  logic [1:0]           next_drive_level_bit;
  logic [1:0]           next_driver_bias_on;
  logic [1:0]           next_openload_detect_on;
  logic                 next_overcurrent_irq_on;
  logic [1:0]           next_overcurrent_flag;
  logic [1:0]           next_event_status;
  logic [1:0]           next_event_mask;
  lsd_pkg::reg8_t       next_trim_test_a;
  lsd_pkg::reg8_t       next_trim_test_b;
  logic                 next_trim_loaded;
  logic                 next_stop_seen;
  logic                 next_irq_q;

  logic [1:0]           src_level;
  logic [1:0]           drive_on;
  logic [1:0]           bias_on;
  logic [1:0]           ol_active;
  logic [1:0]           openload_result;
  logic [1:0]           oc_set;
  logic [1:0]           oc_clear;
  logic [1:0]           data_readback;
  logic                 stop_entry;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  // Protection bits are accepted but do not restrict access
  axi_lite_regs_port #(
    .IDX_W     (4),
    .REG_COUNT (`REG_COUNT)
  ) u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_fire (wr_fire),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_fire (rd_fire),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  // ------------------------------------------------------------
  // Driver channels
  // ------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_chan
    driver_channel u_chan (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .bias_en        (driver_bias_on[i]),
      .ol_en          (openload_detect_on[i]),
      .data_bit       (drive_level_bit[i]),
      .source_is_data (source_is_data[i]),
      .routed_level   (routed_level[i]),
      .oc_flag        (overcurrent_flag[i]),
      .stop_mode      (stop_mode),
      .ol_sense       (openload_sense[i]),
      .src_level      (src_level[i]),
      .drive_on       (drive_on[i]),
      .bias_on        (bias_on[i]),
      .ol_active      (ol_active[i]),
      .ol_result      (openload_result[i])
    );
  end

  assign relay_out_zero    = drive_on[0];
  assign relay_out_one     = drive_on[1];
  assign driver_bias_state = bias_on;
  assign openload_sensing  = ol_active;
  assign irq               = irq_q;

  // ------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      data_readback[i] = driver_bias_on[i] ? src_level[i] : drive_level_bit[i];
    end
    rd_data = `RST_BYTE;
    unique case (rd_idx)
      `IDX_DRIVE_LEVEL: begin
        rd_data = {6'h00, data_readback};
      end
      `IDX_DRIVER_CONFIG: begin
        rd_data = {4'h0, openload_detect_on, driver_bias_on};
      end
      `IDX_TRIM_TEST_A: begin
        rd_data = trim_test_a;
      end
      `IDX_TRIM_TEST_B: begin
        rd_data = trim_test_b;
      end
      `IDX_OPENLOAD_STATUS: begin
        rd_data = {6'h00, openload_result};
      end
      `IDX_IRQ_ENABLE: begin
        rd_data = {overcurrent_irq_on, 7'h00};
      end
      `IDX_OC_FLAGS: begin
        rd_data = {6'h00, overcurrent_flag};
      end
      `IDX_EVENT_STATUS: begin
        rd_data = {6'h00, event_status};
      end
      `IDX_EVENT_MASK: begin
        rd_data = {6'h00, event_mask};
      end
      default: begin
        rd_data = `RST_BYTE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_comb begin
    stop_entry              = stop_mode & ~stop_seen;
    next_stop_seen          = stop_mode;
    next_drive_level_bit    = drive_level_bit;
    next_driver_bias_on     = driver_bias_on;
    next_openload_detect_on = openload_detect_on;
    next_overcurrent_irq_on = overcurrent_irq_on;
    next_event_mask         = event_mask;
    next_trim_test_a        = trim_test_a;
    next_trim_test_b        = trim_test_b;
    next_trim_loaded        = 1'b1;
    if (wr_fire) begin
      unique case (wr_idx)
        `IDX_DRIVE_LEVEL: begin
          next_drive_level_bit = wr_data[1:0];
        end
        `IDX_DRIVER_CONFIG: begin
          next_driver_bias_on     = wr_data[`CFG_BIAS_LSB +: 2];
          next_openload_detect_on = wr_data[`CFG_OL_LSB +: 2];
        end
        `IDX_TRIM_TEST_A: begin
          if (special_mode) begin
            next_trim_test_a = wr_data;
          end
        end
        `IDX_TRIM_TEST_B: begin
          if (special_mode) begin
            next_trim_test_b = wr_data;
          end
        end
        `IDX_IRQ_ENABLE: begin
          next_overcurrent_irq_on = wr_data[`IE_OC_BIT];
        end
        `IDX_EVENT_MASK: begin
          next_event_mask = wr_data[1:0];
        end
        default: begin
          next_event_mask = event_mask;
        end
      endcase
    end
    // A driver sourced from its data bit stays off after stop
    if (stop_entry || stop_mode) begin
      next_drive_level_bit = `RST_PAIR;
    end
    // The trim lands on the first clock after reset release
    if (!trim_loaded) begin
      next_trim_test_a = trim_value;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_level_bit    <= `RST_PAIR;
      driver_bias_on     <= `RST_PAIR;
      openload_detect_on <= `RST_PAIR;
      overcurrent_irq_on <= 1'b0;
      event_mask         <= `RST_PAIR;
      trim_test_a        <= `RST_BYTE;
      trim_test_b        <= `RST_BYTE;
      trim_loaded        <= 1'b0;
      stop_seen          <= 1'b0;
    end else begin
      drive_level_bit    <= next_drive_level_bit;
      driver_bias_on     <= next_driver_bias_on;
      openload_detect_on <= next_openload_detect_on;
      overcurrent_irq_on <= next_overcurrent_irq_on;
      event_mask         <= next_event_mask;
      trim_test_a        <= next_trim_test_a;
      trim_test_b        <= next_trim_test_b;
      trim_loaded        <= next_trim_loaded;
      stop_seen          <= next_stop_seen;
    end
  end

  // ------------------------------------------------------------
  // Over-current flags, events and interrupt
  // ------------------------------------------------------------
  // A detection in the same cycle as a clear keeps the flag set
  always_comb begin
    oc_set   = overcurrent_detect & bias_on;
    oc_clear = `RST_PAIR;
    if (wr_fire && wr_idx == `IDX_OC_FLAGS) begin
      oc_clear = wr_data[1:0];
    end
    // Stop mode does not touch the flags
    next_overcurrent_flag = (overcurrent_flag & ~oc_clear) | oc_set;
    next_event_status = event_status;
    if (rd_fire && rd_idx == `IDX_EVENT_STATUS) begin
      next_event_status = `RST_PAIR;
    end
    next_event_status = next_event_status | (oc_set & ~overcurrent_flag);
    next_irq_q = ~stop_mode
               & ((overcurrent_irq_on & (|overcurrent_flag))
               | (|(event_status & event_mask)));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overcurrent_flag <= `RST_PAIR;
      event_status     <= `RST_PAIR;
      irq_q            <= 1'b0;
    end else begin
      overcurrent_flag <= next_overcurrent_flag;
      event_status     <= next_event_status;
      irq_q            <= next_irq_q;
    end
  end

endmodule

/* dual_lowside_driver_ctrl_props.sv */
module dual_lowside_driver_ctrl_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic        stop_mode,
  input wire logic [1:0]  overcurrent_detect,
  input wire logic        relay_out_zero,
  input wire logic        relay_out_one,
  input wire logic [1:0]  driver_bias_state,
  input wire logic [1:0]  openload_sensing,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic       bus_take;
  logic [1:0] relays;
  assign bus_take = (awvalid && awready) || (wvalid && wready);
  assign relays   = {relay_out_one, relay_out_zero};

  // ------------------------------------------------------------
  // Over-current latch
  // ------------------------------------------------------------
  // A set wins over a same-edge clear, so only later bus writes may release the flag
  sequence oc_hit(int i);
    overcurrent_detect[i] && driver_bias_state[i] && !bus_take;
  endsequence
  sequence bus_quiet;
    (!bus_take) [*3];
  endsequence
  property p_latched(int i);
    oc_hit(i) ##1 bus_quiet |=> !relays[i];
  endproperty

  AST_BIAS0: assert property (relay_out_zero |-> driver_bias_state[0])
    else $error("driver 0 on while unpowered");
  AST_BIAS1: assert property (relay_out_one |-> driver_bias_state[1])
    else $error("driver 1 on while unpowered");
  AST_STOP_OFF: assert property (stop_mode |=> driver_bias_state == 2'b00 && relays == 2'b00)
    else $error("drivers not shut down in stop");
  AST_OC_OFF0: assert property (overcurrent_detect[0] && driver_bias_state[0] |-> ##2 !relay_out_zero)
    else $error("driver 0 not forced off by over-current");
  AST_OC_LATCH0: assert property (p_latched(0))
    else $error("driver 0 released without flag clear");
  AST_OC_LATCH1: assert property (p_latched(1))
    else $error("driver 1 released without flag clear");
  AST_OL_UNDRIVEN: assert property ((openload_sensing & ~(driver_bias_state & ~relays)) == 2'b00)
    else $error("open-load check while driven or unpowered");
  AST_IRQ_RUN: assert property (stop_mode |=> !irq)
    else $error("interrupt raised in stop");
  AST_WR_RESP: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response not on second edge");
  AST_RD_RESP: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
    else $error("read data late or upper bits set");
endmodule

bind dual_lowside_driver_ctrl dual_lowside_driver_ctrl_props u_dual_lowside_driver_ctrl_props (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .rvalid, .rdata, .stop_mode, .overcurrent_detect, .relay_out_zero, .relay_out_one,
  .driver_bias_state, .openload_sensing, .irq
);

/* relay_load_model.sv */
module relay_load_model (
  input wire logic        aclk,
  input wire logic        relay_out_zero,
  input wire logic        relay_out_one,
  input wire logic [1:0]  openload_sensing,
  input wire logic [1:0]  oc_inject,
  input wire logic [1:0]  load_present,
  input wire logic [1:0]  pwm_level,
  output logic     [1:0]  routed_level,
  output logic     [1:0]  overcurrent_detect,
  output logic     [1:0]  openload_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] idle_pattern;

  initial idle_pattern = 2'b01;
  // Sense line is meaningless outside a check, so it never holds a stale level
  always @(posedge aclk) idle_pattern <= ~idle_pattern;
  assign routed_level = pwm_level;
  // A shorted coil only draws excess current while its driver conducts
  assign overcurrent_detect = oc_inject & {relay_out_one, relay_out_zero};
  assign openload_sense = (openload_sensing & load_present) | (~openload_sensing & idle_pattern);
endmodule

/* dual_lowside_driver_ctrl_tb.sv */
module dual_lowside_driver_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] TRIM = 8'hA5;
  localparam int         LIMIT = 5000;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        stop_mode, special_mode, relay_out_zero, relay_out_one, irq;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, resp, source_is_data, routed_level, overcurrent_detect;
  logic [1:0]  openload_sense, driver_bias_state, openload_sensing;
  logic [1:0]  oc_inject, load_present, pwm_level;
  logic [7:0]  rd_val;
  int          failures, n_compared, cycles;

  dual_lowside_driver_ctrl u_dual_lowside_driver_ctrl (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .stop_mode, .special_mode, .trim_value(TRIM),
    .source_is_data, .routed_level, .overcurrent_detect, .openload_sense, .relay_out_zero,
    .relay_out_one, .driver_bias_state, .openload_sensing, .irq
  );
  relay_load_model u_relay_load_model (
    .aclk, .relay_out_zero, .relay_out_one, .openload_sensing, .oc_inject, .load_present,
    .pwm_level, .routed_level, .overcurrent_detect, .openload_sense
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [3:0] idx);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rd_val = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rchk(input string what, input logic [3:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(what, rd_val, exp);
  endtask

  // Packs irq, bias, sensing and both relay outputs for one compare
  task automatic pin_chk(input logic [7:0] exp);
    tick(3);
    chk("pins", {1'b0, irq, driver_bias_state, openload_sensing, relay_out_one, relay_out_zero}, exp);
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, stop_mode, special_mode} = '0;
    {awaddr, araddr, wdata, oc_inject, pwm_level} = '0;
    source_is_data = 2'b11;
    load_present = 2'b10;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("drive_level", 4'h0, 8'h00);
    rchk("driver_config", 4'h1, 8'h00);
    rchk("trim_test_a", 4'h2, TRIM);
    rchk("unmapped", 4'hA, 8'h00);
    chk("unmapped resp", {6'h0, resp}, 8'(lsd_pkg::RESP_SLVERR));
    wr(4'hA, 8'hFF);
    chk("unmapped wr resp", {6'h0, resp}, 8'(lsd_pkg::RESP_SLVERR));
    $display("test reset_values done");

    wr(4'h1, 8'hFF);
    rchk("driver_config", 4'h1, 8'h0F);
    wr(4'h6, 8'hFF);
    rchk("irq_enable", 4'h6, 8'h80);
    wr(4'h6, 8'h00);
    tick(4);
    wr(4'h5, 8'hFF);
    chk("status wr resp", {6'h0, resp}, 8'(lsd_pkg::RESP_OKAY));
    rchk("openload_status", 4'h5, 8'h02);
    pin_chk(8'h3C);
    wr(4'h3, 8'h5A);
    rchk("trim_test_b", 4'h3, 8'h00);
    wr(4'h2, 8'h3C);
    rchk("trim_test_a", 4'h2, TRIM);
    special_mode <= 1'b1;
    wr(4'h3, 8'h5A);
    rchk("trim_test_b", 4'h3, 8'h5A);
    special_mode <= 1'b0;
    $display("test registers done");

    wr(4'h0, 8'hFF);
    rchk("drive_level", 4'h0, 8'h03);
    pin_chk(8'h33);
    source_is_data <= 2'b01;
    pin_chk(8'h39);
    rchk("drive_level", 4'h0, 8'h01);
    pwm_level <= 2'b10;
    pin_chk(8'h33);
    wr(4'h1, 8'h0E);
    pin_chk(8'h22);
    rchk("drive_level", 4'h0, 8'h03);
    wr(4'h0, 8'h02);
    wr(4'h1, 8'h0F);
    pin_chk(8'h36);
    wr(4'h0, 8'h03);
    pin_chk(8'h33);
    $display("test drive done");

    wr(4'h9, 8'h01);
    oc_inject <= 2'b01;
    tick(6);
    oc_inject <= 2'b00;
    pin_chk(8'h72);
    rchk("overcurrent_flags", 4'h7, 8'h01);
    rchk("event_status", 4'h8, 8'h01);
    pin_chk(8'h32);
    rchk("event_status", 4'h8, 8'h00);
    wr(4'h6, 8'h80);
    pin_chk(8'h72);
    wr(4'h7, 8'h00);
    rchk("overcurrent_flags", 4'h7, 8'h01);
    pin_chk(8'h72);
    wr(4'h7, 8'h01);
    rchk("overcurrent_flags", 4'h7, 8'h00);
    pin_chk(8'h33);
    oc_inject <= 2'b10;
    tick(6);
    oc_inject <= 2'b00;
    pin_chk(8'h71);
    $display("test overcurrent done");

    source_is_data <= 2'b00;
    pin_chk(8'h74);
    stop_mode <= 1'b1;
    pin_chk(8'h00);
    source_is_data <= 2'b01;
    rchk("drive_level", 4'h0, 8'h02);
    rchk("overcurrent_flags", 4'h7, 8'h02);
    stop_mode <= 1'b0;
    pin_chk(8'h74);
    wr(4'h7, 8'h02);
    pin_chk(8'h36);
    wr(4'h0, 8'h01);
    pin_chk(8'h33);
    $display("test stop done");
    test_done();
  end
endmodule
